/* logic/sarhc_host.v */
`include "sarhc_regs.vh"
// Summary of operation
// - host may start reading as soon as busy falls
// - no read or select change within 40 ns of convert-start fall
// - abort by second edge or chip-select fall 70 ns after start
// - busy may be tied to step clock to advance channel
// - at least 600 ns from step clock rise to convert-start fall
module sarhc_host (
  input  wire                     core_clk_in,
  input  wire                     arst_n_in,
  input  wire                     start_in,
  input  wire                     abort_in,
  input  wire                     width16_in,
  input  wire                     step_in,
  input  wire [1:0]               chan_in,
  input  wire                     seq_reset_in,
  input  wire                     busy_in,
  input  wire [`SARHC_DATA_W-1:0] data_in,
  output reg                      convert_start_n_out,
  output reg                      chip_select_n_out,
  output reg                      read_n_out,
  output reg                      bus_width_select_out,
  output reg                      mux_step_clock_out,
  output reg                      chan_sel_low_out,
  output reg                      chan_sel_high_out,
  output reg                      sequence_reset_sel_out,
  output reg  [`SARHC_DATA_W-1:0] result_out,
  output reg                      result_valid_out,
  output reg                      aborted_out,
  output reg                      ready_out
);
  // ******************************************************
  // states
  // ******************************************************
  localparam [2:0] ST_IDLE   = 3'h0;
  localparam [2:0] ST_CLOW   = 3'h1;
  localparam [2:0] ST_HOLD   = 3'h2;
  localparam [2:0] ST_BUSY   = 3'h3;
  localparam [2:0] ST_RDLOW  = 3'h4;
  localparam [2:0] ST_RDHIGH = 3'h5;
  localparam [2:0] ST_STEP   = 3'h6;
  localparam [2:0] ST_ABORT  = 3'h7;
  // 32-bit cycle counts, cut to the timer width where they are used
  localparam [31:0] CONVLOW_CYC = `SARHC_CONVLOW_CYC;
  localparam [31:0] HOLDGAP_CYC = `SARHC_HOLD_CYC - `SARHC_CONVLOW_CYC + 1;
  localparam [31:0] RDLOW_CYC   = `SARHC_RDLOW_CYC;
  localparam [31:0] RDHIGH_CYC  = `SARHC_RDHIGH_CYC;
  localparam [31:0] SETTLE_CYC  = `SARHC_SETTLE_CYC;
  localparam [31:0] ABORT_CYC   = `SARHC_ABORT_CYC;

  reg  [2:0] state;
  reg        busy_seen;
  reg        abort_ok;
  reg        settle_load;
  reg        tmr_load;
  reg  [`SARHC_CNT_W-1:0] tmr_val;
  wire       tmr_done;
  wire       settle_done;
  wire       abort_done;
  reg        abort_load;

  sarhc_timer u_tmr (
    .core_clk_in (core_clk_in),
    .arst_n_in   (arst_n_in),
    .load_in     (tmr_load),
    .value_in    (tmr_val),
    .done_out    (tmr_done)
  );
  sarhc_timer u_settle (
    .core_clk_in (core_clk_in),
    .arst_n_in   (arst_n_in),
    .load_in     (settle_load),
    .value_in    (SETTLE_CYC[`SARHC_CNT_W-1:0]),
    .done_out    (settle_done)
  );
  sarhc_timer u_abort (
    .core_clk_in (core_clk_in),
    .arst_n_in   (arst_n_in),
    .load_in     (abort_load),
    .value_in    (ABORT_CYC[`SARHC_CNT_W-1:0]),
    .done_out    (abort_done)
  );

  // ******************************************************
  // sequencer
  // ******************************************************
  always @* begin
    tmr_load    = 1'b0;
    tmr_val     = {`SARHC_CNT_W{1'b0}};
    settle_load = 1'b0;
    abort_load  = 1'b0;
    case (state)
      ST_IDLE: begin
        if (step_in) begin
          settle_load = 1'b1;
        end else if (start_in && settle_done) begin
          tmr_load   = 1'b1;
          tmr_val    = CONVLOW_CYC[`SARHC_CNT_W-1:0];
          abort_load = 1'b1;
        end
      end
      ST_CLOW: begin
        if (tmr_done) begin
          tmr_load = 1'b1;
          tmr_val  = HOLDGAP_CYC[`SARHC_CNT_W-1:0];
        end
      end
      ST_BUSY: begin
        if (busy_seen && !busy_in) begin
          tmr_load = 1'b1;
          tmr_val  = RDLOW_CYC[`SARHC_CNT_W-1:0];
        end
      end
      ST_RDLOW: begin
        if (tmr_done) begin
          tmr_load = 1'b1;
          tmr_val  = RDHIGH_CYC[`SARHC_CNT_W-1:0];
        end
      end
      ST_ABORT: begin
        tmr_load = 1'b1;
        tmr_val  = RDHIGH_CYC[`SARHC_CNT_W-1:0];
      end
      default: begin
        tmr_load = 1'b0;
      end
    endcase
  end

  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state                  <= ST_IDLE;
      busy_seen              <= 1'b0;
      abort_ok               <= 1'b0;
      convert_start_n_out    <= 1'b1;
      chip_select_n_out      <= 1'b1;
      read_n_out             <= 1'b1;
      bus_width_select_out   <= 1'b1;
      mux_step_clock_out     <= 1'b0;
      chan_sel_low_out       <= 1'b0;
      chan_sel_high_out      <= 1'b0;
      sequence_reset_sel_out <= 1'b0;
      result_out             <= {`SARHC_DATA_W{1'b0}};
      result_valid_out       <= 1'b0;
      aborted_out            <= 1'b0;
      ready_out              <= 1'b0;
    end else begin
      result_valid_out <= 1'b0;
      aborted_out      <= 1'b0;
      case (state)
        ST_IDLE: begin
          ready_out <= settle_done && !step_in;
          if (step_in) begin
            chan_sel_low_out       <= chan_in[0];
            chan_sel_high_out      <= chan_in[1];
            sequence_reset_sel_out <= seq_reset_in;
            state                  <= ST_STEP;
          end else if (start_in && settle_done) begin
            // selects change a cycle before convert falls
            chip_select_n_out    <= 1'b0;
            bus_width_select_out <= ~width16_in;
            busy_seen            <= 1'b0;
            abort_ok             <= 1'b0;
            ready_out            <= 1'b0;
            state                <= ST_CLOW;
          end
        end
        ST_STEP: begin
          // selects set one cycle ahead of the rising edge
          mux_step_clock_out <= 1'b1;
          state              <= ST_IDLE;
        end
        ST_CLOW: begin
          // a short busy may come and go before the hold ends
          if (busy_in) begin
            busy_seen <= 1'b1;
          end
          // convert falls one cycle after the selects
          if (tmr_done) begin
            convert_start_n_out <= 1'b1;
            state               <= ST_HOLD;
          end else begin
            convert_start_n_out <= 1'b0;
          end
        end
        ST_HOLD: begin
          if (busy_in) begin
            busy_seen <= 1'b1;
          end
          if (tmr_done) begin
            state <= ST_BUSY;
          end
        end
        ST_BUSY: begin
          if (busy_in) begin
            busy_seen <= 1'b1;
          end
          if (abort_done) begin
            abort_ok <= 1'b1;
          end
          if (abort_in && abort_ok && !busy_seen_fell(busy_seen, busy_in)) begin
            // raise chip-select now so that the next cycle gives its fall
            chip_select_n_out <= 1'b1;
            state             <= ST_ABORT;
          end else if (busy_seen && !busy_in) begin
            read_n_out <= 1'b0;
            state      <= ST_RDLOW;
          end
        end
        ST_RDLOW: begin
          if (tmr_done) begin
            result_out       <= data_in;
            result_valid_out <= 1'b1;
            read_n_out       <= 1'b1;
            chip_select_n_out <= 1'b1;
            state            <= ST_RDHIGH;
          end
        end
        ST_ABORT: begin
          // chip-select fall ends the running conversion
          chip_select_n_out <= 1'b0;
          aborted_out       <= 1'b1;
          state             <= ST_RDHIGH;
        end
        ST_RDHIGH: begin
          // only an abort leaves chip-select low here, for one cycle
          chip_select_n_out <= 1'b1;
          if (tmr_done) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
      // step clock falls ahead of each new step
      if (state != ST_STEP && mux_step_clock_out && start_in) begin
        mux_step_clock_out <= 1'b0;
      end else if (state == ST_IDLE && step_in) begin
        mux_step_clock_out <= 1'b0;
      end
    end
  end

  function busy_seen_fell;
    input seen;
    input bsy;
    begin
      busy_seen_fell = seen & ~bsy;
    end
  endfunction
endmodule // sarhc_host

/* logic/sarhc_regs.vh */
`ifndef SARHC_REGS_VH
`define SARHC_REGS_VH
// ******************************************************
// timing, in ns, and derived cycle counts at 40 ns
// ******************************************************
`define SARHC_CLK_NS          40
`define SARHC_T_HOLD_NS       40
`define SARHC_T_ABORT_NS      70
`define SARHC_T_SETTLE_NS     600
`define SARHC_T_CONVLOW_NS    40
`define SARHC_T_RDLOW_NS      50
`define SARHC_T_RDHIGH_NS     50
// least times round up, never below one cycle
`define SARHC_CYC(ns) (((ns) + `SARHC_CLK_NS - 1) / `SARHC_CLK_NS)
`define SARHC_HOLD_CYC    `SARHC_CYC(`SARHC_T_HOLD_NS)
`define SARHC_ABORT_CYC   `SARHC_CYC(`SARHC_T_ABORT_NS)
`define SARHC_SETTLE_CYC  `SARHC_CYC(`SARHC_T_SETTLE_NS)
`define SARHC_CONVLOW_CYC `SARHC_CYC(`SARHC_T_CONVLOW_NS)
`define SARHC_RDLOW_CYC   `SARHC_CYC(`SARHC_T_RDLOW_NS)
`define SARHC_RDHIGH_CYC  `SARHC_CYC(`SARHC_T_RDHIGH_NS)
`define SARHC_CNT_W       5
`define SARHC_DATA_W      18
`endif

/* logic/sarhc_timer.v */
`include "sarhc_regs.vh"
// ******************************************************
// down counter: load a cycle count, done when it reaches zero
// ******************************************************
module sarhc_timer (
  input  wire                     core_clk_in,
  input  wire                     arst_n_in,
  input  wire                     load_in,
  input  wire [`SARHC_CNT_W-1:0]  value_in,
  output wire                     done_out
);
  reg [`SARHC_CNT_W-1:0] count;
  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      count <= {`SARHC_CNT_W{1'b0}};
    end else if (load_in) begin
      count <= value_in;
    end else if (count != {`SARHC_CNT_W{1'b0}}) begin
      count <= count - {{(`SARHC_CNT_W-1){1'b0}}, 1'b1};
    end
  end
  assign done_out = (count == {`SARHC_CNT_W{1'b0}});
endmodule // sarhc_timer

/* testbench/sarhc_host_asserts.sv */
`include "sarhc_regs.vh"
module sarhc_host_asserts (
  input wire                     core_clk_in,
  input wire                     arst_n_in,
  input wire                     busy_in,
  input wire [`SARHC_DATA_W-1:0] data_in,
  input wire                     convert_start_n_out,
  input wire                     chip_select_n_out,
  input wire                     read_n_out,
  input wire                     bus_width_select_out,
  input wire                     mux_step_clock_out,
  input wire [`SARHC_DATA_W-1:0] result_out,
  input wire                     result_valid_out,
  input wire                     aborted_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);
  // saturating, so a start long after a step never wraps into a false hit
  logic [4:0] since_step;
  logic [4:0] since_conv;
  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      since_step <= 5'h1f;
      since_conv <= 5'h1f;
    end else begin
      since_step <= $rose(mux_step_clock_out) ? 5'h01 :
        since_step + {4'h0, since_step != 5'h1f};
      since_conv <= $fell(convert_start_n_out) ? 5'h01 :
        since_conv + {4'h0, since_conv != 5'h1f};
    end
  end
  start_strobe_a: assert property ($fell(convert_start_n_out) |->
    !chip_select_n_out ##1 convert_start_n_out) else $error("bad start");
  read_hold_a: assert property ($fell(convert_start_n_out) |->
    ##1 (read_n_out && $stable(bus_width_select_out)))
    else $error("read too soon after start");
  settle_gap_a: assert property ($fell(convert_start_n_out) |->
    since_step >= 5'h0f) else $error("start before mux settled");
  no_busy_start_a: assert property ($fell(convert_start_n_out) |->
    !$past(busy_in)) else $error("start while busy");
  read_after_busy_a: assert property ($fell(busy_in) &&
    !chip_select_n_out |-> ##[1:2] !read_n_out) else $error("no read");
  read_width_a: assert property ($fell(read_n_out) |=> !read_n_out
    [*2] ##1 (read_n_out && result_valid_out)) else $error("bad read cycle");
  result_word_a: assert property (result_valid_out |->
    result_out == $past(data_in)) else $error("wrong result word");
  abort_gap_a: assert property ($fell(chip_select_n_out) &&
    aborted_out |-> since_conv >= 5'h02) else $error("abort too early");
  cover property ($rose(result_valid_out));
  cover property (aborted_out);
  cover property ($rose(mux_step_clock_out));
endmodule // sarhc_host_asserts
bind sarhc_host sarhc_host_asserts u_sarhc_host_asserts (.*);

/* testbench/sarhc_adc_model.sv */
module sarhc_adc_model (
  input  wire        cs_n_in,
  input  wire        conv_n_in,
  input  wire        rd_n_in,
  input  wire        mux_clk_in,
  input  wire [1:0]  chan_in,
  input  wire [9:0]  conv_ns_in,
  output logic       busy_out,
  output wire [17:0] data_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0]  chan = 2'h0;
  logic [15:0] n = 16'h0;
  logic [17:0] word = 18'h0;
  initial busy_out = 1'b0;
  always @(posedge mux_clk_in) chan = chan_in;
  always @(negedge conv_n_in) begin
    n = n + 16'h1;
    busy_out <= #30 1'b1;
    word <= #(conv_ns_in - 10'h1) {chan, n};
    busy_out <= #(conv_ns_in) 1'b0;
  end
  // chip select falling mid conversion aborts it; busy drops a little later
  always @(negedge cs_n_in) if (busy_out) busy_out <= #50 1'b0;
  // released bus shows the inverse, never a stale word
  assign data_out = (!rd_n_in && !cs_n_in) ? word : ~word;
endmodule // sarhc_adc_model

/* testbench/test_sar_adc_convert_read_control.sv */
`include "sarhc_regs.vh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; \
  $display("BAD %0t mismatch %h %h", $time, a, b); end end
module test_sar_adc_convert_read_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_in = 1'b0, arst_n_in = 1'b0, start_in = 1'b0;
  logic abort_in = 1'b0, width16_in = 1'b0, step_in = 1'b0;
  logic seq_reset_in = 1'b0;
  logic [1:0] chan_in = 2'h0, chan_exp = 2'h0;
  logic [15:0] n_exp = 16'h0;
  logic [9:0] conv_ns = 10'h12c;
  wire busy_in, convert_start_n_out, chip_select_n_out, read_n_out;
  wire bus_width_select_out, mux_step_clock_out, chan_sel_low_out;
  wire chan_sel_high_out, sequence_reset_sel_out, result_valid_out;
  wire aborted_out, ready_out;
  wire [`SARHC_DATA_W-1:0] data_in, result_out;
  int n_fail = 0, check_count = 0, i;
  always #20 core_clk_in = ~core_clk_in;
  sarhc_host u_sarhc_host (.*);
  sarhc_adc_model u_sarhc_adc_model (.cs_n_in(chip_select_n_out),
    .conv_n_in(convert_start_n_out), .rd_n_in(read_n_out),
    .mux_clk_in(mux_step_clock_out),
    .chan_in({chan_sel_high_out, chan_sel_low_out}),
    .conv_ns_in(conv_ns), .busy_out(busy_in), .data_out(data_in));
  task automatic results();
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // 0 ready, 1 result, 2 abort
  task automatic await(input int which);
    int k;
    for (k = 0; k < 400; k++) begin
      @(negedge core_clk_in);
      if ((which == 0 && ready_out === 1'b1) ||
          (which == 1 && result_valid_out === 1'b1) ||
          (which == 2 && aborted_out === 1'b1)) return;
    end
    n_fail++;
    $display("BAD %0t wait ran out", $time);
    results();
  endtask
  task automatic step(input logic [1:0] c, input logic r);
    await(0);
    step_in = 1'b1;
    chan_in = c;
    seq_reset_in = r;
    @(negedge core_clk_in);
    step_in = 1'b0;
    chan_exp = c;
    repeat (2) @(negedge core_clk_in);
    `CHK(mux_step_clock_out, 1'b1)
    `CHK({chan_sel_high_out, chan_sel_low_out}, c)
    `CHK(sequence_reset_sel_out, r)
  endtask
  task automatic conv(input logic w, input logic ab);
    await(0);
    start_in = 1'b1;
    width16_in = w;
    @(negedge core_clk_in);
    start_in = 1'b0;
    n_exp++;
    if (ab) begin
      repeat (3) @(negedge core_clk_in);
      abort_in = 1'b1;
      await(2);
      abort_in = 1'b0;
      `CHK(result_valid_out, 1'b0)
      `CHK(chip_select_n_out, 1'b0)
      // let the dropped conversion's late events drain
      repeat (30) @(negedge core_clk_in);
    end else begin
      await(1);
      `CHK(result_out, {chan_exp, n_exp})
      `CHK(bus_width_select_out, ~w)
      `CHK(ready_out, 1'b0)
    end
  endtask
  initial begin
    i = $urandom(32'h84d4);
    repeat (6) @(negedge core_clk_in);
    arst_n_in = 1'b1;
    conv(1'b0, 1'b0);
    conv(1'b1, 1'b0);
    // conv waits for ready, so a start after a step is asked only once the settle time is out
    step(2'h3, 1'b1);
    conv(1'b0, 1'b0);
    conv_ns = 10'h384;
    conv(1'b0, 1'b1);
    for (i = 0; i < 12; i++) begin
      // odd lengths keep busy edges off the clock edges
      conv_ns = 10'h065 + 10'(($urandom % 280) * 2);
      if ($urandom % 2) step(2'($urandom), 1'($urandom));
      conv(1'($urandom), 1'b0);
    end
    results();
  end
endmodule // test_sar_adc_convert_read_control
